// ===== rtl/bic_pkg.sv
// Shared constants and types for the bus and interrupt control block.
package bic_pkg;

  // Width of the processor data path.
  localparam int DATA_WIDTH = 8;

  // Full address width; smaller variants drive only the low lines.
  localparam int ADDR_WIDTH = 16;

  // Clock period and the length of one clock phase, both in ns.
  localparam int CLK_PERIOD_NS = 8;
  localparam int PHASE_NS = 32;

  // Clock cycles per phase, rounded down, never below three.
  localparam int PHASE_CYCLES = (PHASE_NS / CLK_PERIOD_NS < 3) ? 3 : PHASE_NS / CLK_PERIOD_NS;

  // Interrupt vector locations.
  localparam logic [15:0] VEC_NMI_LO = 16'hfffa;
  localparam logic [15:0] VEC_NMI_HI = 16'hfffb;
  localparam logic [15:0] VEC_IRQ_LO = 16'hfffe;
  localparam logic [15:0] VEC_IRQ_HI = 16'hffff;

  // The stack lives on page one.
  localparam logic [7:0] STACK_PAGE = 8'h01;

  // Position of the interrupt mask flag in the status register.
  localparam int MASK_BIT = 2;

  // Positions of each pin in the synchroniser bundle.
  localparam int PIN_IRQ = 0;
  localparam int PIN_NMI = 1;
  localparam int PIN_RDY = 2;
  localparam int PIN_SO = 3;
  localparam int PIN_DRV_EN = 4;
  localparam int PIN_DATA = 5;
  localparam int PIN_COUNT = 13;

  // Interrupt entry sequence states.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PUSH_HI = 6'h02,
    ST_PUSH_LO = 6'h04,
    ST_PUSH_P = 6'h08,
    ST_VEC_LO = 6'h10,
    ST_VEC_HI = 6'h20
  } bic_entry_type;

endpackage

// ===== rtl/bic_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock into phase one and phase two of one bus cycle.
module bic_phase_gen #(
  parameter int PHASE_CYCLES = bic_pkg::PHASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic ph1_load,
  output logic ph1_end,
  output logic ph2_end,
  output logic in_ph2
);

  // Counter width covers both phases of the cycle.
  localparam int CW = $clog2(2 * PHASE_CYCLES);

  // Position inside the bus cycle.
  logic [CW-1:0] count_ff;

  // The counter wraps at the end of phase two, starting a new cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= '0;
    end else if (count_ff == CW'(2 * PHASE_CYCLES - 1)) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + CW'(1);
    end
  end

  // Loading one cycle into phase one lets the core settle its next address first.
  assign ph1_load = (count_ff == CW'(1));
  assign ph1_end = (count_ff == CW'(PHASE_CYCLES - 1));
  assign ph2_end = (count_ff == CW'(2 * PHASE_CYCLES - 1));
  assign in_ph2 = (count_ff >= CW'(PHASE_CYCLES));

endmodule
`default_nettype wire

// ===== rtl/bic_bus_int_ctrl.sv
// Operation
// - address lines sized per variant width.
// - maskable request taken after instruction, mask clear.
// - entry saves program counter and status.
// - mask flag set after state saved.
// - maskable vector from FFFE low, FFFF high.
// - interrupts recognised only while ready high; the code gates only the maskable request on ready.
// - falling edge requests non-maskable interrupt.
// - non-maskable entry ignores mask flag.
// - non-maskable vector from FFFA, FFFB.
// - sample in phase two, enter next phase one.
// - eight-bit bidirectional data bus, tri-state drivers.
// - drivers enabled only while driver enable high.
// - drivers off during read cycles.
// - overflow input falling edge sets overflow.
// - ready halts any cycle except writes.
// - halt keeps current address on lines.
// - ready low on write defers halt.
// - stay halted while ready low in phase two.
`timescale 1ns/1ps
`default_nettype none
module bic_bus_int_ctrl #(
  parameter int ADDR_WIDTH = bic_pkg::ADDR_WIDTH,
  parameter int PHASE_CYCLES = bic_pkg::PHASE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic IRQ_N,
  input wire logic NMI_N,
  input wire logic RDY,
  input wire logic SO_N,
  input wire logic DATA_DRIVER_ENABLE,
  input wire logic [7:0] DATA_LINES_IN,
  output logic [7:0] DATA_LINES_OUT,
  output logic DATA_LINES_OE,
  output logic [ADDR_WIDTH-1:0] ADDRESS_LINES,
  output logic RW,
  input wire logic [15:0] CORE_ADDR,
  input wire logic [7:0] CORE_WDATA,
  input wire logic CORE_WRITE,
  input wire logic CORE_INSTR_DONE,
  input wire logic [15:0] CORE_PC,
  input wire logic [7:0] CORE_STATUS,
  input wire logic [7:0] CORE_SP,
  output logic [7:0] CORE_READ_DATA,
  output logic CORE_CYCLE_DONE,
  output logic CORE_HOLD,
  output logic [15:0] NEW_PC,
  output logic [7:0] NEW_SP,
  output logic NEW_PC_LOAD,
  output logic SET_MASK,
  output logic SET_OVERFLOW
);

  // Vector address for the chosen interrupt kind and byte.
  function automatic logic [15:0] vec_addr(input logic nmi, input logic hi);
    return nmi ? (hi ? bic_pkg::VEC_NMI_HI : bic_pkg::VEC_NMI_LO) : (hi ? bic_pkg::VEC_IRQ_HI : bic_pkg::VEC_IRQ_LO);
  endfunction

  // Phase strobes from the divider.
  logic ph1_load;
  logic ph1_end;
  logic ph2_end;
  logic in_ph2;

  bic_phase_gen #(
    .PHASE_CYCLES(PHASE_CYCLES)
  ) u_phase (
    .clk(CLOCK),
    .rst(RST),
    .ph1_load(ph1_load),
    .ph1_end(ph1_end),
    .ph2_end(ph2_end),
    .in_ph2(in_ph2)
  );

  // Two-stage synchroniser for every pin input.
  logic [bic_pkg::PIN_COUNT-1:0] pin_meta_ff;
  logic [bic_pkg::PIN_COUNT-1:0] pin_sync_ff;

  // Only the second stage is ever read; the first may be metastable.
  always_ff @(posedge CLOCK) begin
    pin_meta_ff <= {DATA_LINES_IN, DATA_DRIVER_ENABLE, SO_N, RDY, NMI_N, IRQ_N};
    pin_sync_ff <= pin_meta_ff;
  end

  // Named views of the synchronised pins.
  logic irq_s;
  logic nmi_s;
  logic rdy_s;
  logic so_s;
  logic drv_en_s;
  logic [7:0] rd_data;
  assign irq_s = pin_sync_ff[bic_pkg::PIN_IRQ];
  assign nmi_s = pin_sync_ff[bic_pkg::PIN_NMI];
  assign rdy_s = pin_sync_ff[bic_pkg::PIN_RDY];
  assign so_s = pin_sync_ff[bic_pkg::PIN_SO];
  assign drv_en_s = pin_sync_ff[bic_pkg::PIN_DRV_EN];
  assign rd_data = pin_sync_ff[bic_pkg::PIN_DATA +: 8];

  // Bus cycle and halt state.
  logic halted_ff;
  logic cyc_write_ff;
  logic cycle_done;

  // A cycle only completes when it was not stalled by ready.
  assign cycle_done = ph2_end & ~halted_ff;

  // Entry sequence state and saved context.
  bic_pkg::bic_entry_type state_ff;
  logic is_nmi_ff;
  logic [7:0] sp_ff;
  logic [15:0] pc_save_ff;
  logic [7:0] p_save_ff;
  logic [7:0] vec_lo_ff;
  logic nmi_pend_ff;
  logic nmi_prev_ff;
  logic so_prev_ff;

  // Interrupt decisions at the end of phase two.
  logic irq_req;
  logic take_nmi;
  logic take_irq;
  logic take_any;
  assign irq_req = ~irq_s & rdy_s;
  assign take_nmi = cycle_done & (state_ff == bic_pkg::ST_IDLE) & CORE_INSTR_DONE & nmi_pend_ff;
  assign take_irq = cycle_done & (state_ff == bic_pkg::ST_IDLE) & CORE_INSTR_DONE & ~nmi_pend_ff & irq_req
                    & ~CORE_STATUS[bic_pkg::MASK_BIT];
  assign take_any = take_nmi | take_irq;

  // Address, data and direction for the next bus cycle.
  logic [15:0] nxt_addr;
  logic [7:0] nxt_wdata;
  logic nxt_write;

  // The entry sequence owns the bus; otherwise the core does.
  always_comb begin
    nxt_addr = CORE_ADDR;
    nxt_wdata = CORE_WDATA;
    nxt_write = CORE_WRITE;
    unique case (state_ff)
      bic_pkg::ST_PUSH_HI: begin
        nxt_addr = {bic_pkg::STACK_PAGE, sp_ff};
        nxt_wdata = pc_save_ff[15:8];
        nxt_write = 1'b1;
      end
      bic_pkg::ST_PUSH_LO: begin
        nxt_addr = {bic_pkg::STACK_PAGE, sp_ff};
        nxt_wdata = pc_save_ff[7:0];
        nxt_write = 1'b1;
      end
      bic_pkg::ST_PUSH_P: begin
        nxt_addr = {bic_pkg::STACK_PAGE, sp_ff};
        nxt_wdata = p_save_ff;
        nxt_write = 1'b1;
      end
      bic_pkg::ST_VEC_LO: begin
        nxt_addr = vec_addr(is_nmi_ff, 1'b0);
        nxt_write = 1'b0;
      end
      bic_pkg::ST_VEC_HI: begin
        nxt_addr = vec_addr(is_nmi_ff, 1'b1);
        nxt_write = 1'b0;
      end
      default: begin // Idle, and any illegal code, leaves the bus to the core.
        nxt_addr = CORE_ADDR;
      end
    endcase
  end

  // Drive the bus one clock into phase one of each cycle; a halted cycle keeps its address.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ADDRESS_LINES <= '0;
      DATA_LINES_OUT <= 8'h00;
      RW <= 1'b1;
      cyc_write_ff <= 1'b0;
    end else if (ph1_load && !halted_ff) begin
      ADDRESS_LINES <= nxt_addr[ADDR_WIDTH-1:0];
      DATA_LINES_OUT <= nxt_wdata;
      RW <= ~nxt_write;
      cyc_write_ff <= nxt_write;
    end
  end

  // Drivers on from one clock after phase two begins to one clock after it ends, on a write with the enable pin high.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DATA_LINES_OE <= 1'b0;
    end else begin
      DATA_LINES_OE <= cyc_write_ff & in_ph2 & drv_en_s;
    end
  end

  // Ready stalls read cycles at the end of phase one, never write cycles.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      halted_ff <= 1'b0;
    end else if (ph1_end && !rdy_s && !cyc_write_ff) begin
      halted_ff <= 1'b1;
    end else if (ph2_end && halted_ff && rdy_s) begin
      halted_ff <= 1'b0;
    end
  end

  // Each falling edge of the non-maskable input is latched once; a new edge wins over the clear.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      nmi_prev_ff <= 1'b1;
      nmi_pend_ff <= 1'b0;
    end else if (ph2_end) begin
      nmi_prev_ff <= nmi_s;
      if (nmi_prev_ff && !nmi_s) begin
        nmi_pend_ff <= 1'b1;
      end else if (take_nmi) begin
        nmi_pend_ff <= 1'b0;
      end
    end
  end

  // Overflow input is sampled at the trailing edge of phase one.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      so_prev_ff <= 1'b1;
      SET_OVERFLOW <= 1'b0;
    end else begin
      SET_OVERFLOW <= ph1_end & so_prev_ff & ~so_s;
      if (ph1_end) begin
        so_prev_ff <= so_s;
      end
    end
  end

  // Entry sequencer advances one state per completed bus cycle.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= bic_pkg::ST_IDLE;
      is_nmi_ff <= 1'b0;
      sp_ff <= 8'h00;
      pc_save_ff <= 16'h0000;
      p_save_ff <= 8'h00;
      vec_lo_ff <= 8'h00;
    end else if (take_any) begin
      state_ff <= bic_pkg::ST_PUSH_HI;
      is_nmi_ff <= take_nmi;
      sp_ff <= CORE_SP;
      pc_save_ff <= CORE_PC;
      p_save_ff <= CORE_STATUS;
    end else if (cycle_done) begin
      unique case (state_ff)
        bic_pkg::ST_IDLE: begin
          state_ff <= bic_pkg::ST_IDLE;
        end
        bic_pkg::ST_PUSH_HI: begin
          state_ff <= bic_pkg::ST_PUSH_LO;
          sp_ff <= sp_ff - 8'h01;
        end
        bic_pkg::ST_PUSH_LO: begin
          state_ff <= bic_pkg::ST_PUSH_P;
          sp_ff <= sp_ff - 8'h01;
        end
        bic_pkg::ST_PUSH_P: begin
          state_ff <= bic_pkg::ST_VEC_LO;
          sp_ff <= sp_ff - 8'h01;
        end
        bic_pkg::ST_VEC_LO: begin
          state_ff <= bic_pkg::ST_VEC_HI;
          vec_lo_ff <= rd_data;
        end
        bic_pkg::ST_VEC_HI: begin
          state_ff <= bic_pkg::ST_IDLE;
        end
        default: begin
          state_ff <= bic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Results handed back to the core, each a registered pulse or value.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CORE_READ_DATA <= 8'h00;
      CORE_CYCLE_DONE <= 1'b0;
      CORE_HOLD <= 1'b0;
      NEW_PC <= 16'h0000;
      NEW_SP <= 8'h00;
      NEW_PC_LOAD <= 1'b0;
      SET_MASK <= 1'b0;
    end else begin
      CORE_CYCLE_DONE <= cycle_done & (state_ff == bic_pkg::ST_IDLE);
      CORE_HOLD <= halted_ff | take_any | (state_ff != bic_pkg::ST_IDLE);
      SET_MASK <= cycle_done & (state_ff == bic_pkg::ST_PUSH_P);
      NEW_PC_LOAD <= cycle_done & (state_ff == bic_pkg::ST_VEC_HI);
      if (cycle_done && !cyc_write_ff) begin
        CORE_READ_DATA <= rd_data;
      end
      if (cycle_done && state_ff == bic_pkg::ST_VEC_HI) begin
        NEW_PC <= {rd_data, vec_lo_ff};
        NEW_SP <= sp_ff;
      end
    end
  end

  // Checks on the logic above.
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  chk_read_no_drive: assert property (DATA_LINES_OE |-> !RW)
    else $error("Data drivers on during a read cycle.");
  chk_enable_gates_drive: assert property (DATA_LINES_OE |-> $past(drv_en_s) && $past(in_ph2))
    else $error("Data drivers on without enable in phase two.");
  chk_irq_mask_block: assert property (cycle_done && state_ff == bic_pkg::ST_IDLE && !nmi_pend_ff
    && (CORE_STATUS[bic_pkg::MASK_BIT] || irq_s || !rdy_s) |=> state_ff == bic_pkg::ST_IDLE)
    else $error("Maskable entry taken while masked or not ready.");
  chk_nmi_edge_latch: assert property (ph2_end && nmi_prev_ff && !nmi_s |=> nmi_pend_ff)
    else $error("Non-maskable edge was not latched.");
  chk_push_order: assert property (take_any |=> state_ff == bic_pkg::ST_PUSH_HI && sp_ff == $past(CORE_SP))
    else $error("Entry did not start with the high byte push.");
  chk_sp_decrement: assert property (cycle_done && state_ff == bic_pkg::ST_PUSH_LO
    |=> sp_ff == $past(sp_ff) - 8'h01)
    else $error("Stack pointer not decremented after push.");
  chk_vec_addr: assert property (ph1_load && !halted_ff && state_ff == bic_pkg::ST_VEC_LO
    |=> ADDRESS_LINES == ADDR_WIDTH'(is_nmi_ff ? bic_pkg::VEC_NMI_LO : bic_pkg::VEC_IRQ_LO))
    else $error("Wrong vector address on the bus.");
  chk_halt_holds_addr: assert property (halted_ff && ph1_load |=> $stable(ADDRESS_LINES))
    else $error("Address changed while halted.");
  chk_write_no_halt: assert property (ph1_end && cyc_write_ff && !halted_ff |=> !halted_ff)
    else $error("Write cycle was halted.");
  chk_so_set: assert property (ph1_end && so_prev_ff && !so_s |=> SET_OVERFLOW ##1 !SET_OVERFLOW)
    else $error("Overflow set pulse missing.");
  chk_mask_after_push: assert property (cycle_done && state_ff == bic_pkg::ST_PUSH_P |=> SET_MASK)
    else $error("Mask flag not set after state saved.");
endmodule
`default_nettype wire

// ===== verification/bic_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory and peripherals on the far side of the pins.
module bic_mem_model (
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic rw,
  input wire logic [7:0] dout,
  input wire logic oe,
  output logic [7:0] din,
  output int oe_in_read
);
  // Byte store, filled so that neighbouring addresses in one page read differently.
  logic [7:0] mem [0:65535];
  // Last bus level; a floating bus shows its inverse so no stale byte passes.
  logic [7:0] last_ff;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8);
    end
    last_ff = 8'h00;
    oe_in_read = 0;
  end
  // Wire level: the block when enabled, memory on reads, otherwise floating.
  always_comb begin
    if (oe) begin
      din = dout;
    end else if (rw) begin
      din = mem[addr];
    end else begin
      din = ~last_ff;
    end
  end
  // Capture writes and count any drive seen during a read.
  always @(posedge clk) begin
    last_ff <= din;
    if (oe && !rw) begin
      mem[addr] <= dout;
    end
    if (oe && rw) begin
      oe_in_read <= oe_in_read + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench; the bench plays the core and the interrupt sources.
module tb_top;
  logic clock, rst, irq_n, nmi_n, rdy, so_n, drv_en, wr, instr_done;
  logic [15:0] caddr, pc, addr, new_pc, cap_pc;
  logic [7:0] wdata, status, sp, din, dout, rdata, new_sp, cap_sp;
  logic oe, rw, cdone, hold, pc_load, set_mask, set_ovf;
  int oe_bad;
  int n_mask = 0;
  int n_ovf = 0;
  int n_load = 0;
  int mismatches = 0;
  int checked = 0;

  bic_bus_int_ctrl dut_u (.CLOCK(clock), .RST(rst), .IRQ_N(irq_n), .NMI_N(nmi_n), .RDY(rdy), .SO_N(so_n),
    .DATA_DRIVER_ENABLE(drv_en), .DATA_LINES_IN(din), .DATA_LINES_OUT(dout), .DATA_LINES_OE(oe),
    .ADDRESS_LINES(addr), .RW(rw), .CORE_ADDR(caddr), .CORE_WDATA(wdata), .CORE_WRITE(wr),
    .CORE_INSTR_DONE(instr_done), .CORE_PC(pc), .CORE_STATUS(status), .CORE_SP(sp),
    .CORE_READ_DATA(rdata), .CORE_CYCLE_DONE(cdone), .CORE_HOLD(hold), .NEW_PC(new_pc),
    .NEW_SP(new_sp), .NEW_PC_LOAD(pc_load), .SET_MASK(set_mask), .SET_OVERFLOW(set_ovf));
  bic_mem_model mem_u (.clk(clock), .addr(addr), .rw(rw), .dout(dout), .oe(oe), .din(din), .oe_in_read(oe_bad));

  // Free-running 125 MHz clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Count the one-cycle pulses, since a task polling them could miss one.
  always @(posedge clock) begin
    if (set_mask === 1'b1) n_mask <= n_mask + 1;
    if (set_ovf === 1'b1) n_ovf <= n_ovf + 1;
    if (pc_load === 1'b1) begin
      n_load <= n_load + 1;
      cap_pc <= new_pc;
      cap_sp <= new_sp;
    end
  end

  // Byte pattern that the memory model starts with.
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction

  // Compare one value and record the outcome.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Wait until the chosen pulse counter (overflow or load) reaches a target, bounded.
  task automatic wait_cnt(input bit ovf, input int tgt);
    for (int i = 0; i < 200 && (ovf ? n_ovf : n_load) < tgt; i++) @(posedge clock);
  endtask

  // Wait for the presented cycle to complete, or for the block to hold the core.
  task automatic wait_done(input bit stop_on_hold);
    for (int i = 0; i < 100; i++) begin
      @(posedge clock);
      if (cdone === 1'b1 || (stop_on_hold && hold === 1'b1)) return;
    end
    chk("cycle completion", 16'h0001, 16'h0000);
  endtask

  // Present one core cycle; values land before the block latches them.
  task automatic core_cycle(input logic [15:0] a, input logic w, input logic [7:0] d, input logic last);
    caddr <= a;
    wr <= w;
    wdata <= d;
    instr_done <= last;
    wait_done(1'b0);
  endtask

  // Reads and writes, with the driver enable and a write under a low ready.
  task automatic t_rw;
    core_cycle(16'h1234, 1'b0, 8'h00, 1'b0);
    chk("read data", {8'h00, pat(16'h1234)}, {8'h00, rdata});
    rdy <= 1'b0;
    core_cycle(16'h0300, 1'b1, 8'h5a, 1'b0);
    rdy <= 1'b1;
    chk("written byte", 16'h005a, {8'h00, mem_u.mem[16'h0300]});
    drv_en <= 1'b0;
    core_cycle(16'h0301, 1'b1, 8'ha5, 1'b0);
    drv_en <= 1'b1;
    chk("disabled write", {8'h00, pat(16'h0301)}, {8'h00, mem_u.mem[16'h0301]});
    core_cycle(16'h0000, 1'b0, 8'h00, 1'b0);
    $display("test read_write finished");
  endtask

  // A low ready halts a read on its address until ready returns.
  task automatic t_halt;
    int k;
    k = 0;
    rdy <= 1'b0;
    caddr <= 16'h0abc;
    repeat (40) begin
      @(posedge clock);
      if (cdone === 1'b1) k++;
    end
    chk("halt hold", 16'h0001, {15'h0000, hold});
    chk("halt address", 16'h0abc, addr);
    chk("halt completions", 16'h0000, 16'(k));
    rdy <= 1'b1;
    wait_done(1'b0);
    chk("read after halt", {8'h00, pat(16'h0abc)}, {8'h00, rdata});
    $display("test halt finished");
  endtask

  // Run an instruction end with a request pending and check the whole entry.
  task automatic entry(input logic [15:0] vec, input logic [7:0] st);
    int t;
    int m;
    t = n_load + 1;
    m = n_mask + 1;
    core_cycle(16'h0000, 1'b0, 8'h00, 1'b0);
    pc <= 16'hc3a5;
    sp <= 8'hf0;
    status <= st;
    caddr <= 16'h0200;
    instr_done <= 1'b1;
    wait_done(1'b1);
    instr_done <= 1'b0;
    caddr <= 16'h0000;
    wait_cnt(1'b0, t);
    chk("vector", {pat(vec + 16'h0001), pat(vec)}, cap_pc);
    chk("stack pointer", 16'h00ed, {8'h00, cap_sp});
    chk("push pc high", 16'h00c3, {8'h00, mem_u.mem[16'h01f0]});
    chk("push pc low", 16'h00a5, {8'h00, mem_u.mem[16'h01ef]});
    chk("push status", {8'h00, st}, {8'h00, mem_u.mem[16'h01ee]});
    chk("mask pulses", 16'(m), 16'(n_mask));
  endtask

  // Maskable requests: masked, refused while not ready, then taken.
  task automatic t_irq;
    int n;
    n = n_load;
    irq_n <= 1'b0;
    status <= 8'h04;
    core_cycle(16'h0210, 1'b0, 8'h00, 1'b1);
    core_cycle(16'h0000, 1'b0, 8'h00, 1'b0);
    chk("masked entry", 16'(n), 16'(n_load));
    status <= 8'h00;
    rdy <= 1'b0;
    core_cycle(16'h0310, 1'b1, 8'h11, 1'b1);
    rdy <= 1'b1;
    core_cycle(16'h0000, 1'b0, 8'h00, 1'b0);
    chk("not ready entry", 16'(n), 16'(n_load));
    entry(bic_pkg::VEC_IRQ_LO, 8'h00);
    irq_n <= 1'b1;
    $display("test maskable finished");
  endtask

  // Non-maskable edge taken despite the mask, and only once per edge.
  task automatic t_nmi;
    int n;
    nmi_n <= 1'b0;
    entry(bic_pkg::VEC_NMI_LO, 8'h04);
    n = n_load;
    core_cycle(16'h0000, 1'b0, 8'h00, 1'b0);
    core_cycle(16'h0220, 1'b0, 8'h00, 1'b1);
    core_cycle(16'h0000, 1'b0, 8'h00, 1'b0);
    chk("second service", 16'(n), 16'(n_load));
    nmi_n <= 1'b1;
    $display("test non_maskable finished");
  endtask

  // One overflow pulse per falling edge, none while the pin stays low.
  task automatic t_so;
    int n;
    n = n_ovf + 1;
    so_n <= 1'b0;
    wait_cnt(1'b1, n);
    repeat (30) @(posedge clock);
    chk("overflow pulses", 16'(n), 16'(n_ovf));
    so_n <= 1'b1;
    $display("test overflow finished");
  endtask

  // Print the counts and the verdict, then stop.
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cut a hang short; the full run takes a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {irq_n, nmi_n, rdy, so_n, drv_en} = 5'h1f;
    {wr, instr_done} = 2'h0;
    caddr = 16'h0000;
    wdata = 8'h00;
    pc = 16'h0000;
    status = 8'h00;
    sp = 8'hff;
    repeat (8) @(posedge clock);
    chk("reset direction", 16'h0001, {15'h0000, rw});
    chk("reset drive", 16'h0000, {15'h0000, oe});
    chk("address width", 16'h0010, 16'($bits(dut_u.ADDRESS_LINES)));
    rst <= 1'b0;
    t_rw();
    t_halt();
    t_irq();
    t_nmi();
    t_so();
    chk("drive during read", 16'h0000, 16'(oe_bad));
    conclude();
  end
endmodule
`default_nettype wire
